// ==== core/device_end.sv ====
// device end of the host port: command intake, reports, fatal errors
`timescale 1ns/10ps
`include "hpf_cfg.svh"

module device_end
(
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    // host port
    hpf_if.device                      port,
    // fatal event sources, their report data and init completion
    input  wire logic                  power_fail,
    input  wire logic [15:0]           bad_irq_level,
    input  wire logic                  trap_hit,
    input  wire logic                  pool_fault,
    input  wire logic                  selftest_fail,
    input  wire hpf_pkg::byte_t        selftest_code,
    input  wire logic [15:0]           saved_wp,
    input  wire logic [15:0]           saved_pc,
    input  wire logic                  init_done,
    // other input word sources
    input  wire logic                  receive_reprocess_flag,
    input  wire logic                  out_fifo_room_flag,
    input  wire logic                  poll_indicator,
    // command hand-off to firmware
    output logic                       cmd_valid,
    output hpf_pkg::cmd_block_t        cmd_bytes,
    input  wire logic                  done_valid,
    input  wire hpf_pkg::byte_t        done_code,
    input  wire logic [31:0]           done_info,
    // modem and status
    output logic                       modem_enable,
    output logic                       reset_pending_flag
);
    import hpf_pkg::*;

    typedef struct packed {
        dev_state_e  st;
        logic [2:0]  cmd_idx;
        cmd_block_t  cmd;
        rpt_block_t  rpt;
        logic [2:0]  rpt_idx;
        logic        rpt_busy;
        logic        out_rdy;
        logic        modem_ok;
        logic        pass_cmd;
        logic [15:0] in_word;
    } dev_s;

    dev_s       s_q;
    dev_s       s_d;
    logic       buf_in_ready;
    logic       buf_out_valid;
    logic [8:0] buf_out_data;
    logic       pop;

    ////////////////////////////////////////////////////////////////////////////
    // command byte buffer

    byte_buffer u_buf
    (
        .clk       (clk),
        .rst_b     (rst_b),
        .in_valid  (port.out_wr),
        .in_ready  (buf_in_ready),
        .in_data   (port.out_word[8:0]),
        .out_valid (buf_out_valid),
        .out_ready (pop),
        .out_data  (buf_out_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // next state

    function automatic byte_t irq_code(input logic [15:0] lvl);
        byte_t c;
        c = 8'h00;
        for (int i = 15; i >= 3; i--)
        begin
            if (lvl[i] && i != 4)
            begin
                c = `CODE_IRQ_BASE + 8'(i);
            end
        end
        return c;
    endfunction

    always_comb
    begin
        cmd_block_t c;
        byte_t      fcode;
        logic       mism;
        logic       fatal;
        logic       ready_bit;
        c     = s_q.cmd;
        fcode = 8'h00;
        mism  = 1'b0;
        fatal = 1'b0;
        ready_bit = 1'b0;
        pop   = 1'b0;
        s_d   = s_q;
        s_d.pass_cmd = 1'b0;

        if (s_q.rpt_busy && port.in_rd)
        begin
            if (s_q.rpt_idx == `RPT_BYTES - 3'd1)
            begin
                s_d.rpt_busy = 1'b0;
            end
            else
            begin
                s_d.rpt_idx = s_q.rpt_idx + 3'd1;
            end
        end

        // run-time fatal sources, highest priority first
        if (s_q.st == DEV_NEED_TEST || s_q.st == DEV_NORMAL || s_q.st == DEV_WAIT_USER)
        begin
            if (power_fail)
            begin
                fatal        = 1'b1;
                fcode        = `CODE_POWER_FAIL;
                s_d.modem_ok = 1'b0;
            end
            else if (irq_code(bad_irq_level) != 8'h00)
            begin
                fatal = 1'b1;
                fcode = irq_code(bad_irq_level);
            end
            else if (trap_hit)
            begin
                fatal = 1'b1;
                fcode = `CODE_TRAP;
            end
        end

        case (s_q.st)
            DEV_RESET:
            begin
                s_d.st = DEV_INIT;
            end
            DEV_INIT:
            begin
                if (selftest_fail)
                begin
                    s_d.st       = DEV_FATAL;
                    s_d.rpt      = {selftest_code, 32'h0, `FATAL_MARK};
                    s_d.rpt_busy = 1'b1;
                    s_d.rpt_idx  = 3'd0;
                end
                else if (pool_fault)
                begin
                    s_d.st       = DEV_FATAL;
                    s_d.rpt      = {`CODE_POOL_FAULT, 32'h0, `FATAL_MARK};
                    s_d.rpt_busy = 1'b1;
                    s_d.rpt_idx  = 3'd0;
                end
                else if (init_done)
                begin
                    s_d.st      = DEV_NEED_TEST;
                    s_d.out_rdy = 1'b1;
                end
            end
            DEV_NEED_TEST, DEV_NORMAL:
            begin
                if (!fatal && buf_out_valid && !s_q.rpt_busy)
                begin
                    pop         = 1'b1;
                    s_d.out_rdy = 1'b1;
                    if (buf_out_data[8])
                    begin
                        c[0]        = buf_out_data[7:0];
                        s_d.cmd_idx = 3'd1;
                    end
                    else if (s_q.cmd_idx != 3'd0)
                    begin
                        c[s_q.cmd_idx] = buf_out_data[7:0];
                        s_d.cmd_idx    = s_q.cmd_idx + 3'd1;
                        if (s_q.cmd_idx == `CMD_BYTES - 3'd1)
                        begin
                            s_d.cmd_idx = 3'd0;
                            if (c[0] == `CMD_IFACE_TEST)
                            begin
                                mism = c[1] != `PATTERN_B1 || c[2] != `PATTERN_B2 ||
                                       c[3] != `PATTERN_B3 || c[4] != `PATTERN_B4;
                                s_d.rpt      = {mism ? `CODE_PATTERN_BAD : 8'h00,
                                                c[4], c[3], c[2], c[1], c[0]};
                                s_d.rpt_busy = 1'b1;
                                s_d.rpt_idx  = 3'd0;
                                if (!mism)
                                begin
                                    s_d.st = DEV_NORMAL;
                                end
                            end
                            else if (s_q.st == DEV_NORMAL)
                            begin
                                s_d.pass_cmd = 1'b1;
                                s_d.st       = DEV_WAIT_USER;
                            end
                        end
                    end
                    s_d.cmd = c;
                end
            end
            DEV_WAIT_USER:
            begin
                if (!fatal && done_valid)
                begin
                    s_d.rpt[0] = (done_code >= `ERR_LO && done_code <= `ERR_HI) ?
                                 {1'b1, s_q.cmd[0][6:0]} : s_q.cmd[0];
                    s_d.rpt[4:1] = done_info;
                    s_d.rpt[5]   = done_code;
                    s_d.rpt_busy = 1'b1;
                    s_d.rpt_idx  = 3'd0;
                    s_d.st       = DEV_NORMAL;
                end
            end
            DEV_FATAL:
            begin
                pop         = buf_out_valid;
                s_d.out_rdy = 1'b1;
            end
            default:
            begin
                s_d.st = DEV_RESET;
            end
        endcase

        if (fatal)
        begin
            s_d.st       = DEV_FATAL;
            s_d.rpt      = {fcode, saved_pc, saved_wp, `FATAL_MARK};
            s_d.rpt_busy = 1'b1;
            s_d.rpt_idx  = 3'd0;
            s_d.cmd_idx  = 3'd0;
        end

        if (port.out_wr)
        begin
            s_d.out_rdy = 1'b0;
        end

        if (port.out_word[`OUT_RESET_BIT])
        begin
            s_d          = '0;
            s_d.st       = DEV_RESET;
            s_d.modem_ok = 1'b1;
            pop          = buf_out_valid;
        end
        // input word, registered
        ready_bit = s_d.out_rdy && buf_in_ready;
        s_d.in_word = '0;
        s_d.in_word[7:0] = s_d.rpt_busy ? s_d.rpt[s_d.rpt_idx] : 8'h00;
        s_d.in_word[`IN_STATUS_BIT]      = s_d.rpt_busy;
        s_d.in_word[`IN_REPROCESS_BIT]   = receive_reprocess_flag;
        s_d.in_word[`IN_VALID_BIT]       = s_d.rpt_busy;
        s_d.in_word[`IN_PENDING_BIT]     = s_d.st == DEV_RESET || s_d.st == DEV_INIT ||
                                           s_d.st == DEV_FATAL;
        s_d.in_word[`IN_FIFO_ROOM_BIT]   = out_fifo_room_flag;
        s_d.in_word[`IN_WRITE_READY_BIT] = ready_bit;
        s_d.in_word[`IN_POLL_BIT]        = poll_indicator;
        s_d.in_word[`IN_SUMMARY_BIT]     = port.out_word[`OUT_HOST_IE_BIT] && (
            (s_d.rpt_busy && port.out_word[`OUT_VALID_IE_BIT]) ||
            (out_fifo_room_flag && port.out_word[`OUT_ROOM_IE_BIT]) ||
            (ready_bit && port.out_word[`OUT_READY_IE_BIT]));
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register and outputs

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_q          <= '0;
            s_q.st       <= DEV_RESET;
            s_q.modem_ok <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign port.in_word        = s_q.in_word;
    assign cmd_valid           = s_q.pass_cmd;
    assign cmd_bytes           = s_q.cmd;
    assign modem_enable        = s_q.modem_ok;
    assign reset_pending_flag  = s_q.in_word[`IN_PENDING_BIT];
endmodule

// ==== core/hpf_cfg.svh ====
// offsets, field positions, codes and timing counts of the host port
`ifndef HPF_CFG_SVH
`define HPF_CFG_SVH

// input word flag positions
`define IN_STATUS_BIT       4'd8
`define IN_REPROCESS_BIT    4'd9
`define IN_VALID_BIT        4'd10
`define IN_PENDING_BIT      4'd11
`define IN_FIFO_ROOM_BIT    4'd12
`define IN_WRITE_READY_BIT  4'd13
`define IN_POLL_BIT         4'd14
`define IN_SUMMARY_BIT      4'd15

// output word control positions
`define OUT_CMD_BIT         4'd8
`define OUT_VALID_IE_BIT    4'd10
`define OUT_RESET_BIT       4'd11
`define OUT_ROOM_IE_BIT     4'd12
`define OUT_READY_IE_BIT    4'd13
`define OUT_HOST_IE_BIT     4'd15

// report and command layout
`define CMD_BYTES           3'd5
`define RPT_BYTES           3'd6
`define FATAL_MARK          8'hff
`define ERR_LO              8'h60
`define ERR_HI              8'h7f
`define CODE_POWER_FAIL     8'h61
`define CODE_IRQ_BASE       8'h60
`define CODE_TRAP           8'h70
`define CODE_POOL_FAULT     8'h7d
`define CMD_IFACE_TEST      8'h0f
`define PATTERN_B1          8'haa
`define PATTERN_B2          8'h55
`define PATTERN_B3          8'hff
`define PATTERN_B4          8'h00
`define CODE_PATTERN_BAD    8'h32

// timing
`define CLK_HZ              64'd100000000
`define MR_WAIT_S           64'd5
`define MR_WAIT_CYCLES      (`MR_WAIT_S * `CLK_HZ)

`endif

// ==== core/hpf_pkg.sv ====
// types shared by both ends of the host port
`include "hpf_cfg.svh"

package hpf_pkg;

    typedef logic [7:0]        byte_t;
    typedef logic [4:0][7:0]   cmd_block_t;
    typedef logic [5:0][7:0]   rpt_block_t;

    typedef enum logic [2:0]
    {
        DEV_RESET,
        DEV_INIT,
        DEV_NEED_TEST,
        DEV_NORMAL,
        DEV_WAIT_USER,
        DEV_FATAL
    } dev_state_e;

    typedef enum logic [2:0]
    {
        H_IDLE,
        H_MR,
        H_WAIT,
        H_SEND,
        H_READ,
        H_READY,
        H_DEAD
    } host_state_e;

    typedef enum logic [1:0]
    {
        MODE_USER,
        MODE_TEST,
        MODE_SELFTEST
    } host_mode_e;

endpackage

// ==== core/hpf_if.sv ====
// bit-addressed port between host and device, same clock
`timescale 1ns/10ps

interface hpf_if;
    logic [15:0] out_word;
    logic        out_wr;
    logic [15:0] in_word;
    logic        in_rd;

    modport device
    (
        input  out_word,
        input  out_wr,
        input  in_rd,
        output in_word
    );

    modport host
    (
        output out_word,
        output out_wr,
        output in_rd,
        input  in_word
    );
endinterface

// ==== core/byte_buffer.sv ====
// two-entry buffer for command bytes written by the host
`timescale 1ns/10ps

module byte_buffer
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // filling side
    input  wire logic       in_valid,
    output logic            in_ready,
    input  wire logic [8:0] in_data,
    // draining side
    output logic            out_valid,
    input  wire logic       out_ready,
    output logic [8:0]      out_data
);
    typedef struct packed {
        logic [1:0][8:0] mem;
        logic            wr_ptr;
        logic            rd_ptr;
        logic [1:0]      count;
    } buf_s;

    buf_s s_q;
    buf_s s_d;

    assign in_ready  = (s_q.count != 2'd2);
    assign out_valid = (s_q.count != 2'd0);
    assign out_data  = s_q.mem[s_q.rd_ptr];

    always_comb
    begin
        logic push;
        logic pop;
        push = in_valid && in_ready;
        pop  = out_valid && out_ready;
        s_d  = s_q;
        if (push)
        begin
            s_d.mem[s_q.wr_ptr] = in_data;
            s_d.wr_ptr          = ~s_q.wr_ptr;
        end
        if (pop)
        begin
            s_d.rd_ptr = ~s_q.rd_ptr;
        end
        s_d.count = s_q.count + 2'(push) - 2'(pop);
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end
endmodule

// ==== core/host_end.sv ====
// host end of the host port: power-up reset, interface test, commands
`timescale 1ns/10ps
`include "hpf_cfg.svh"

module host_end
#(
    parameter logic [31:0] RESET_WAIT_CYCLES = 32'(`MR_WAIT_CYCLES)
)
(
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    // host port
    hpf_if.host                        port,
    // control from driver
    input  wire logic                  power_up,
    input  wire logic [3:0]            irq_enables,
    // command request
    input  wire logic                  cmd_valid,
    output logic                       cmd_ready,
    input  wire hpf_pkg::cmd_block_t   cmd_bytes,
    // report answer
    output logic                       rpt_valid,
    output hpf_pkg::rpt_block_t        rpt_bytes,
    // status
    output logic                       link_ready,
    output logic                       board_dead,
    output logic                       reset_failed
);
    import hpf_pkg::*;

    typedef struct packed {
        host_state_e st;
        host_mode_e  mode;
        logic [31:0] tmr;
        logic [2:0]  idx;
        cmd_block_t  cmd;
        rpt_block_t  rpt;
        logic [8:0]  data;
        logic        mr;
        logic        wr;
        logic        rd;
        logic        gap;
        logic        rpt_v;
        logic        fail;
    } host_s;

    host_s s_q;
    host_s s_d;

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        logic ok;
        ok  = 1'b0;
        s_d = s_q;
        s_d.mr    = 1'b0;
        s_d.wr    = 1'b0;
        s_d.rd    = 1'b0;
        s_d.gap   = 1'b0;
        s_d.rpt_v = 1'b0;

        case (s_q.st)
            H_IDLE:
            begin
            end
            H_MR:
            begin
                s_d.tmr = 32'd0;
                s_d.st  = H_WAIT;
            end
            H_WAIT:
            begin
                s_d.tmr = s_q.tmr + 32'd1;
                if (port.in_word[`IN_VALID_BIT])
                begin
                    s_d.mode = MODE_SELFTEST;
                    s_d.idx  = 3'd0;
                    s_d.st   = H_READ;
                end
                else if (!port.in_word[`IN_PENDING_BIT])
                begin
                    s_d.cmd  = {`PATTERN_B4, `PATTERN_B3, `PATTERN_B2,
                                `PATTERN_B1, `CMD_IFACE_TEST};
                    s_d.mode = MODE_TEST;
                    s_d.idx  = 3'd0;
                    s_d.st   = H_SEND;
                end
                else if (s_q.tmr >= RESET_WAIT_CYCLES - 32'd1)
                begin
                    s_d.st = H_DEAD;
                end
            end
            H_SEND:
            begin
                if (!s_q.gap && !s_q.wr && port.in_word[`IN_WRITE_READY_BIT])
                begin
                    s_d.data = {s_q.idx == 3'd0, s_q.cmd[s_q.idx]};
                    s_d.wr   = 1'b1;
                    s_d.gap  = 1'b1;
                    s_d.idx  = s_q.idx + 3'd1;
                    if (s_q.idx == `CMD_BYTES - 3'd1)
                    begin
                        s_d.idx = 3'd0;
                        s_d.st  = H_READ;
                    end
                end
            end
            H_READ:
            begin
                if (!s_q.rd && port.in_word[`IN_VALID_BIT])
                begin
                    s_d.rpt[s_q.idx] = port.in_word[7:0];
                    s_d.rd  = 1'b1;
                    s_d.idx = s_q.idx + 3'd1;
                    if (s_q.idx == `RPT_BYTES - 3'd1)
                    begin
                        s_d.idx   = 3'd0;
                        s_d.rpt_v = 1'b1;
                        ok = s_d.rpt[4:0] == s_q.cmd && s_d.rpt[5] == 8'h00;
                        case (s_q.mode)
                            MODE_TEST:
                            begin
                                s_d.st   = ok ? H_READY : H_IDLE;
                                s_d.fail = !ok;
                            end
                            MODE_SELFTEST:
                            begin
                                s_d.st   = H_IDLE;
                                s_d.fail = 1'b1;
                            end
                            default:
                            begin
                                s_d.st = H_READY;
                            end
                        endcase
                    end
                end
            end
            H_READY:
            begin
                // unsolicited report, a fatal error; rd guard skips the stale byte
                if (!s_q.rd && port.in_word[`IN_VALID_BIT])
                begin
                    s_d.mode = MODE_USER;
                    s_d.idx  = 3'd0;
                    s_d.st   = H_READ;
                end
                else if (cmd_valid)
                begin
                    s_d.cmd  = cmd_bytes;
                    s_d.mode = MODE_USER;
                    s_d.idx  = 3'd0;
                    s_d.st   = H_SEND;
                end
            end
            H_DEAD:
            begin
            end
            default:
            begin
                s_d.st = H_IDLE;
            end
        endcase

        if (power_up)
        begin
            s_d.mr   = 1'b1;
            s_d.fail = 1'b0;
            s_d.st   = H_MR;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register and outputs

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    always_comb
    begin
        port.out_word                     = '0;
        port.out_word[8:0]                = s_q.data;
        port.out_word[`OUT_VALID_IE_BIT]  = irq_enables[0];
        port.out_word[`OUT_RESET_BIT]     = s_q.mr;
        port.out_word[`OUT_ROOM_IE_BIT]   = irq_enables[1];
        port.out_word[`OUT_READY_IE_BIT]  = irq_enables[2];
        port.out_word[`OUT_HOST_IE_BIT]   = irq_enables[3];
    end

    assign port.out_wr   = s_q.wr;
    assign port.in_rd    = s_q.rd;
    assign cmd_ready     = (s_q.st == H_READY);
    assign rpt_valid     = s_q.rpt_v;
    assign rpt_bytes     = s_q.rpt;
    assign link_ready    = (s_q.st == H_READY);
    assign board_dead    = (s_q.st == H_DEAD);
    assign reset_failed  = s_q.fail;
endmodule

// ==== test/host_port_fatal_error_reset_checker.sv ====
// assertions on the wires between host and device ends
`timescale 1ns/10ps
module host_port_fatal_error_reset_checker
(
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_b,
    // port wires
    input wire logic [15:0] out_word,
    input wire logic        out_wr,
    input wire logic [15:0] in_word,
    input wire logic        in_rd
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////
    AST_MR_PEND: assert property (out_word[11] |=> in_word[11])
        else $error("pending flag missing after reset request");
    AST_MR_ONE: assert property ($rose(out_word[11]) |=> !out_word[11])
        else $error("reset request longer than one cycle");
    AST_WR_CLEAR: assert property (out_wr |=> !in_word[13])
        else $error("write ready kept after write");
    AST_WR_SEEN: assert property (out_wr |-> $past(in_word[13]))
        else $error("write without write ready");
    AST_WR_GAP: assert property (out_wr |=> !out_wr)
        else $error("writes back to back");
    AST_HOLD: assert property (in_word[10] && !in_rd && !out_word[11]
        |=> in_word[10] && ($stable(in_word[7:0]) || in_word[11]))
        else $error("report byte dropped before read");
    AST_FATAL_FF: assert property (in_word[10] && in_word[11]
        && !$past(in_word[10] && in_word[11]) |-> in_word[7:0] == 8'hff)
        else $error("fatal report without marker");
    AST_STATUS: assert property (in_word[10] |-> in_word[8])
        else $error("status flag missing with valid byte");
    AST_RD_VALID: assert property (in_rd |-> in_word[10])
        else $error("read without valid byte");
    cover property (in_word[10] && in_word[11] && in_rd);
    cover property (out_wr && out_word[8]);
    cover property ($fell(in_word[11]));
endmodule

// ==== test/host_port_fatal_error_reset_tb_top.sv ====
// scenarios for both ends of the host port
`timescale 1ns/10ps
module host_port_fatal_error_reset_tb_top;
    import hpf_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, power_up = 1'b0, power_fail = 1'b0, cmd_go = 1'b0;
    logic selftest_fail = 1'b0, init_done = 1'b0, done_valid = 1'b0, trap_hit = 1'b0;
    logic [15:0] bad_irq_level = 16'h0, saved_wp = 16'h1a2b, saved_pc = 16'h3c4d;
    logic [3:0] irq_enables = 4'h5;
    byte_t selftest_code = 8'h0, done_code = 8'h0;
    logic [31:0] done_info = 32'h0;
    cmd_block_t cmd_blk = '0, dev_bytes, seen;
    rpt_block_t rpt_bytes;
    logic dev_valid, modem_enable, reset_pending_flag, rpt_valid, link_ready;
    logic board_dead, reset_failed, cmd_ready;
    int bad_count = 0, samples_checked = 0, ncmd = 0;
    hpf_if hpf_if_i ();
    device_end device_end_i (.clk, .rst_b, .port(hpf_if_i), .power_fail, .bad_irq_level,
        .trap_hit, .pool_fault(1'b0), .selftest_fail, .selftest_code, .saved_wp,
        .saved_pc, .init_done, .receive_reprocess_flag(1'b0), .out_fifo_room_flag(1'b0),
        .poll_indicator(1'b0), .cmd_valid(dev_valid), .cmd_bytes(dev_bytes), .done_valid,
        .done_code, .done_info, .modem_enable, .reset_pending_flag);
    host_end #(.RESET_WAIT_CYCLES(32'd200)) host_end_i (.clk, .rst_b, .port(hpf_if_i),
        .power_up, .irq_enables, .cmd_valid(cmd_go), .cmd_ready, .cmd_bytes(cmd_blk),
        .rpt_valid, .rpt_bytes, .link_ready, .board_dead, .reset_failed);
    host_port_fatal_error_reset_checker host_port_fatal_error_reset_checker_i (.clk, .rst_b,
        .out_word(hpf_if_i.out_word), .out_wr(hpf_if_i.out_wr),
        .in_word(hpf_if_i.in_word), .in_rd(hpf_if_i.in_rd));
    initial
        forever #5 clk = ~clk;
    // firmware stand-in answers one cycle after each command
    always @(posedge clk)
        done_valid <= dev_valid;
    always @(posedge clk)
        if (dev_valid)
        begin
            seen <= dev_bytes;
            ncmd <= ncmd + 1;
        end
    ////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input logic ok, input string what);
        samples_checked++;
        if (ok !== 1'b1)
        begin
            bad_count++;
            $display("mismatch %0t %s", $time, what);
        end
    endtask
    task automatic wait_for(ref logic sig, input logic lvl, input int lim);
        int n;
        n = 0;
        #1;
        while (sig !== lvl && n < lim)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        check(sig === lvl, "awaited level");
        if (sig !== lvl)
            print_verdict();
    endtask
    task automatic bring(input logic fail, input logic init);
        @(posedge clk);
        selftest_fail <= fail;
        power_fail <= 1'b0;
        init_done <= 1'b0;
        power_up <= 1'b1;
        @(posedge clk);
        power_up <= 1'b0;
        repeat (6) @(posedge clk);
        init_done <= init;
    endtask
    task automatic send(input cmd_block_t c, input byte_t code, input logic [31:0] info);
        @(posedge clk);
        cmd_blk <= c;
        done_code <= code;
        done_info <= info;
        cmd_go <= 1'b1;
        @(posedge clk);
        cmd_go <= 1'b0;
    endtask
    task automatic get_rpt(input rpt_block_t exp);
        wait_for(rpt_valid, 1'b1, 300);
        check(rpt_bytes === exp, "report bytes");
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_selftest();
        selftest_code <= 8'h73;
        bring(1'b1, 1'b0);
        get_rpt({8'h73, 32'h0, 8'hff});
        wait_for(reset_failed, 1'b1, 20);
        $display("test selftest ended");
    endtask
    task automatic t_command();
        bring(1'b0, 1'b1);
        wait_for(link_ready, 1'b1, 300);
        check(cmd_ready === 1'b1, "host not ready for commands");
        send({8'h14, 8'h13, 8'h12, 8'h11, 8'h20}, 8'h65, 32'h14131211);
        get_rpt({8'h65, 32'h14131211, 8'ha0});
        check(seen === {8'h14, 8'h13, 8'h12, 8'h11, 8'h20}, "command bytes");
        $display("test command ended");
    endtask
    task automatic t_irq_fatal();
        @(posedge clk);
        bad_irq_level <= 16'h0210;
        get_rpt({8'h69, saved_pc, saved_wp, 8'hff});
        @(posedge clk);
        bad_irq_level <= 16'h0;
        send({8'h14, 8'h13, 8'h12, 8'h11, 8'h20}, 8'h00, 32'h0);
        repeat (60) @(posedge clk);
        check(ncmd === 1, "command taken after fatal");
        check(reset_pending_flag === 1'b1, "pending after fatal");
        $display("test interrupt fatal ended");
    endtask
    task automatic t_power();
        bring(1'b0, 1'b1);
        wait_for(reset_pending_flag, 1'b0, 300);
        @(posedge clk);
        power_fail <= 1'b1;
        get_rpt({8'h61, saved_pc, saved_wp, 8'hff});
        check(modem_enable === 1'b0, "modem leads kept");
        $display("test power fail ended");
    endtask
    task automatic t_trap();
        bring(1'b0, 1'b1);
        wait_for(link_ready, 1'b1, 300);
        @(posedge clk);
        trap_hit <= 1'b1;
        get_rpt({8'h70, saved_pc, saved_wp, 8'hff});
        @(posedge clk);
        trap_hit <= 1'b0;
        $display("test trap ended");
    endtask
    task automatic t_timeout();
        bring(1'b0, 1'b0);
        wait_for(board_dead, 1'b1, 400);
        $display("test timeout ended");
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        t_selftest();
        t_command();
        t_irq_fatal();
        t_power();
        t_trap();
        t_timeout();
        print_verdict();
    end
endmodule
